// >>> hdl/bmar_pkg.sv
// Constants shared by the battery monitor and alarm reporting block.
// Assumes a 100 MHz system clock and that reset release marks control power-up.
package bmar_pkg;

  // Clock rate and documented power-up times
  localparam int unsigned CLK_HZ         = 100_000_000;
  localparam int unsigned HOLD_TIME_S    = 5;
  localparam int unsigned MONITOR_TIME_S = 4;
  localparam int unsigned HOLD_CYCLES    = HOLD_TIME_S * CLK_HZ;
  localparam int unsigned MONITOR_CYCLES = MONITOR_TIME_S * CLK_HZ;

  // Emergency message give-up time and panel character dwell
  localparam int unsigned EMCY_TIMEOUT_CYCLES = 1000;
  localparam int unsigned CHAR_DWELL_CYCLES   = 50_000_000;

  // Object indices and status word layout
  localparam logic [15:0] OBJ_ERROR_CODE  = 16'h603F;
  localparam logic [15:0] OBJ_STATUS_WORD = 16'h6041;
  localparam int unsigned STATUS_FAULT_BIT = 3;
  localparam logic [15:0] OBJ_RESET_VALUE = 16'h0000;

  // Battery alarm-select digit values
  localparam logic [3:0] BAT_SEL_ALARM = 4'h0;
  localparam logic [3:0] BAT_SEL_WARN  = 4'h1;

  // Alarm table: index order is also the reporting priority
  localparam int unsigned NUM_ALARMS  = 7;
  localparam int unsigned IDX_PRM_SUM = 0;
  localparam int unsigned IDX_PRM_FMT = 1;
  localparam int unsigned IDX_SYS_SUM = 2;
  localparam int unsigned IDX_SYS_24  = 3;
  localparam int unsigned IDX_SYS_25  = 4;
  localparam int unsigned IDX_MAIN    = 5;
  localparam int unsigned IDX_BATTERY = 6;
  localparam logic [NUM_ALARMS-1:0][11:0] ALARM_CODES = {
    12'h830, 12'h030, 12'h025, 12'h024, 12'h022, 12'h021, 12'h020};
  localparam logic [NUM_ALARMS-1:0] ALARM_RESETTABLE = 7'h20;
  localparam logic [NUM_ALARMS-1:0] ALARM_STOP_GROUP_ONE = 7'h3F;
  localparam logic [NUM_ALARMS-1:0] ALARM_CLEAR = 7'h00;

  // Panel character codes: 00..0F are hex digits
  localparam logic [4:0] CHR_A     = 5'h10;
  localparam logic [4:0] CHR_DOT   = 5'h11;
  localparam logic [4:0] CHR_BLANK = 5'h1F;
  localparam logic [2:0] SEQ_LAST  = 3'h5;

  // Power-up sequence states
  typedef enum logic [3:0] {
    ST_HOLD   = 4'b0001,
    ST_WINDOW = 4'b0010,
    ST_CONT   = 4'b0100,
    ST_DONE   = 4'b1000
  } bmar_state_t;

endpackage

// >>> hdl/bmar_panel_seq.sv
// Panel display sequencer: shows an alarm code one character at a time.
// Assumes the code is stable while active; a new code shows from the next clock at the current sequence position.
`timescale 1ns/1ps
`default_nettype none
module bmar_panel_seq #(
  parameter int unsigned DWELL = bmar_pkg::CHAR_DWELL_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        active,
  input  wire logic [11:0] code,
  output logic      [4:0]  panelChar
);

  logic [31:0] dwell_q;
  logic [2:0]  seq_q;
  logic [4:0]  char_q;
  logic [4:0]  char_d;
  wire         dwellEnd = (dwell_q == DWELL - 1);

  // Sequence A . d2 d1 d0 blank, then repeat
  always_comb begin
    unique case (seq_q)
      3'h0:    char_d = bmar_pkg::CHR_A;
      3'h1:    char_d = bmar_pkg::CHR_DOT;
      3'h2:    char_d = {1'b0, code[11:8]};
      3'h3:    char_d = {1'b0, code[7:4]};
      3'h4:    char_d = {1'b0, code[3:0]};
      default: char_d = bmar_pkg::CHR_BLANK;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dwell_q <= 32'h0;
      seq_q   <= 3'h0;
      char_q  <= bmar_pkg::CHR_BLANK;
    end else if (!active) begin
      dwell_q <= 32'h0;
      seq_q   <= 3'h0;
      char_q  <= bmar_pkg::CHR_BLANK;
    end else begin
      dwell_q <= dwellEnd ? 32'h0 : dwell_q + 32'h1;
      if (dwellEnd) begin
        seq_q <= (seq_q == bmar_pkg::SEQ_LAST) ? 3'h0 : seq_q + 3'h1;
      end
      char_q  <= char_d;
    end
  end

  assign panelChar = char_q;

endmodule
`default_nettype wire

// >>> hdl/bmar_alarm_unit.sv
// Battery monitor and alarm reporting unit.
// Assumes reset release is control power-up and reset assertion is power-down.
// Notes on behaviour
// - Battery low input raises alarm or warning.
// - Digit zero gives alarm; change needs restart.
// - Digit one gives warning instead of alarm.
// - Alarm mode: fault output, then windowed check.
// - Alarm mode ignores lows after window closes.
// - Warning mode: fault output, then continuous check.
// - Battery alarm clears only at power-down.
// - Status fault bit follows any active alarm.
// - Error-code object holds active alarm code.
// - Emergency message per new alarm, best-effort.
// - Panel shows alarm code character by character.
// - Dark panel while a non-blank character shows during alarm is system error.
// - Resettable alarm clears on a reset request once cause is gone.
// - Non-resettable alarms ignore reset requests.
// - Parameter data and format errors, non-resettable.
// - Internal program errors use system codes.
// - Main-circuit detection error is resettable.
`timescale 1ns/1ps
`default_nettype none
module bmar_alarm_unit #(
  parameter int unsigned HOLD_CYCLES    = bmar_pkg::HOLD_CYCLES,
  parameter int unsigned MONITOR_CYCLES = bmar_pkg::MONITOR_CYCLES,
  parameter int unsigned CHAR_DWELL     = bmar_pkg::CHAR_DWELL_CYCLES,
  parameter int unsigned EMCY_TIMEOUT   = bmar_pkg::EMCY_TIMEOUT_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        batteryLow,
  input  wire logic [3:0]  batteryAlarmSelectParam,
  input  wire logic        paramChecksumErr,
  input  wire logic        paramFormatErr,
  input  wire logic        systemChecksumErr,
  input  wire logic        programErrA,
  input  wire logic        programErrB,
  input  wire logic        mainCircuitErr,
  input  wire logic        panelLit,
  input  wire logic        alarmResetReq,
  input  wire logic        objReadReq,
  input  wire logic [15:0] objIndex,
  output logic             objReadAck,
  output logic             objReadErr,
  output logic      [15:0] objReadData,
  output logic             emcyValid,
  output logic      [15:0] emcyCode,
  input  wire logic        emcyReady,
  output logic             servoFaultOutput,
  output logic             batteryWarning,
  output logic             stopGroupOne,
  output logic      [4:0]  panelChar
);

  localparam int unsigned N = bmar_pkg::NUM_ALARMS;

  bmar_pkg::bmar_state_t state_q;
  bmar_pkg::bmar_state_t state_d;
  logic [31:0]  timer_q;
  logic         modeCaptured_q;
  logic         modeWarn_q;
  logic [N-1:0] alarm_q;
  logic [N-1:0] alarm_d;
  logic [N-1:0] cond;
  logic [15:0]  errorCode_q;
  logic [15:0]  statusWord_q;
  logic         newAlarm_q;
  logic         emcyValid_q;
  logic [15:0]  emcyCode_q;
  logic [31:0]  emcyTimer_q;
  logic         objAck_q;
  logic         objErr_q;
  logic [15:0]  objData_q;
  logic         servoFault_q;
  logic         batWarn_q;
  logic         stopGroup_q;
  logic         panelDark_q;
  logic [11:0]  activeCode;

  // Sequence decode
  wire stHold    = (state_q == bmar_pkg::ST_HOLD);
  wire stWindow  = (state_q == bmar_pkg::ST_WINDOW);
  wire stCont    = (state_q == bmar_pkg::ST_CONT);
  wire holdEnd   = stHold && (timer_q == HOLD_CYCLES - 1);
  wire windowEnd = stWindow && (timer_q == MONITOR_CYCLES - 1);
  wire anyAlarm  = |alarm_q;
  wire newSet    = |(alarm_d & ~alarm_q);
  wire emcyGiveUp = emcyValid_q && (emcyTimer_q == EMCY_TIMEOUT - 1);

  // Mode as seen during the first cycle after power-up
  wire modeWarnNow = modeCaptured_q ? modeWarn_q
                   : (batteryAlarmSelectParam == bmar_pkg::BAT_SEL_WARN);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      bmar_pkg::ST_HOLD: begin
        if (holdEnd) begin
          state_d = modeWarnNow ? bmar_pkg::ST_CONT : bmar_pkg::ST_WINDOW;
        end
      end
      bmar_pkg::ST_WINDOW: begin
        if (windowEnd) begin
          state_d = bmar_pkg::ST_DONE;
        end
      end
      bmar_pkg::ST_CONT: state_d = bmar_pkg::ST_CONT;
      bmar_pkg::ST_DONE: state_d = bmar_pkg::ST_DONE;
      default:           state_d = bmar_pkg::ST_HOLD;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= bmar_pkg::ST_HOLD;
      timer_q <= 32'h0;
    end else begin
      state_q <= state_d;
      timer_q <= (holdEnd || windowEnd || !(stHold || stWindow)) ? 32'h0 : timer_q + 32'h1;
    end
  end

  // The select digit is caught once after release, so edits wait for a restart
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      modeCaptured_q <= 1'b0;
      modeWarn_q     <= 1'b0;
    end else if (!modeCaptured_q) begin
      modeCaptured_q <= 1'b1;
      modeWarn_q     <= (batteryAlarmSelectParam == bmar_pkg::BAT_SEL_WARN);
    end
  end

  // Alarm causes; battery low is sampled only inside the window in alarm mode
  assign cond[bmar_pkg::IDX_PRM_SUM] = paramChecksumErr;
  assign cond[bmar_pkg::IDX_PRM_FMT] = paramFormatErr;
  assign cond[bmar_pkg::IDX_SYS_SUM] = systemChecksumErr;
  assign cond[bmar_pkg::IDX_SYS_24]  = programErrA || panelDark_q;
  assign cond[bmar_pkg::IDX_SYS_25]  = programErrB;
  assign cond[bmar_pkg::IDX_MAIN]    = mainCircuitErr;
  assign cond[bmar_pkg::IDX_BATTERY] = batteryLow && stWindow && !modeWarn_q;

  // Set wins over an alarm-reset in the same cycle
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_alarm
      wire clearOk = bmar_pkg::ALARM_RESETTABLE[gi] && alarmResetReq && !cond[gi];
      assign alarm_d[gi] = cond[gi] || (alarm_q[gi] && !clearOk);
    end
  endgenerate

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      alarm_q <= bmar_pkg::ALARM_CLEAR;
    end else begin
      alarm_q <= alarm_d;
    end
  end

  // Lowest index reports first
  always_comb begin
    activeCode = 12'h000;
    for (int i = N - 1; i >= 0; i--) begin
      if (alarm_q[i]) begin
        activeCode = bmar_pkg::ALARM_CODES[i];
      end
    end
  end

  // A dark panel is only judged one cycle after a character was driven
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      panelDark_q <= 1'b0;
    end else begin
      panelDark_q <= anyAlarm && (panelChar != bmar_pkg::CHR_BLANK) && !panelLit;
    end
  end

  // Object values and discrete outputs
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      errorCode_q  <= bmar_pkg::OBJ_RESET_VALUE;
      statusWord_q <= bmar_pkg::OBJ_RESET_VALUE;
      servoFault_q <= 1'b1;
      batWarn_q    <= 1'b0;
      stopGroup_q  <= 1'b0;
    end else begin
      errorCode_q  <= {4'h0, activeCode};
      statusWord_q <= anyAlarm ? (16'h0001 << bmar_pkg::STATUS_FAULT_BIT) : 16'h0000;
      servoFault_q <= stHold || anyAlarm;
      batWarn_q    <= batteryLow && stCont && modeWarn_q;
      stopGroup_q  <= |(alarm_q & bmar_pkg::ALARM_STOP_GROUP_ONE);
    end
  end

  // Object read port: answer one cycle after the request
  wire idxErr  = (objIndex == bmar_pkg::OBJ_ERROR_CODE);
  wire idxStat = (objIndex == bmar_pkg::OBJ_STATUS_WORD);
  wire [15:0] objSel = idxErr ? errorCode_q : (idxStat ? statusWord_q : 16'h0000);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      objAck_q  <= 1'b0;
      objErr_q  <= 1'b0;
      objData_q <= 16'h0000;
    end else begin
      objAck_q  <= objReadReq;
      objErr_q  <= objReadReq && !(idxErr || idxStat);
      objData_q <= objReadReq ? objSel : 16'h0000;
    end
  end

  // Emergency message; dropped after a timeout since delivery is not guaranteed
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      newAlarm_q  <= 1'b0;
      emcyValid_q <= 1'b0;
      emcyCode_q  <= 16'h0000;
      emcyTimer_q <= 32'h0;
    end else begin
      newAlarm_q <= newSet;
      if (newAlarm_q) begin
        emcyValid_q <= 1'b1;
        emcyCode_q  <= {4'h0, activeCode};
        emcyTimer_q <= 32'h0;
      end else if (emcyValid_q && (emcyReady || emcyGiveUp)) begin
        emcyValid_q <= 1'b0;
        emcyTimer_q <= 32'h0;
      end else if (emcyValid_q) begin
        emcyTimer_q <= emcyTimer_q + 32'h1;
      end
    end
  end

  bmar_panel_seq #(
    .DWELL (CHAR_DWELL)
  ) u_panel (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .active    (anyAlarm),
    .code      (activeCode),
    .panelChar (panelChar)
  );

  assign objReadAck       = objAck_q;
  assign objReadErr       = objErr_q;
  assign objReadData      = objData_q;
  assign emcyValid        = emcyValid_q;
  assign emcyCode         = emcyCode_q;
  assign servoFaultOutput = servoFault_q;
  assign batteryWarning   = batWarn_q;
  assign stopGroupOne     = stopGroup_q;

  a_fault_bit_set: assert property (@(posedge clk) disable iff (sys_rst)
    anyAlarm |=> statusWord_q[bmar_pkg::STATUS_FAULT_BIT])
    else $error("fault bit not set during alarm");

  a_fault_bit_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !anyAlarm |=> statusWord_q == 16'h0000)
    else $error("status word not clear without alarm");

  a_battery_window: assert property (@(posedge clk) disable iff (sys_rst)
    (stWindow && batteryLow && !modeWarn_q) |=> alarm_q[bmar_pkg::IDX_BATTERY] ##1
    alarm_q[bmar_pkg::IDX_BATTERY])
    else $error("battery alarm not raised in window");

  a_battery_sticky: assert property (@(posedge clk) disable iff (sys_rst)
    alarm_q[bmar_pkg::IDX_BATTERY] |=> alarm_q[bmar_pkg::IDX_BATTERY])
    else $error("battery alarm cleared without power-down");

  a_late_low_ignored: assert property (@(posedge clk) disable iff (sys_rst)
    (!stWindow && !alarm_q[bmar_pkg::IDX_BATTERY]) |=> !alarm_q[bmar_pkg::IDX_BATTERY])
    else $error("battery alarm raised outside window");

  a_warn_no_alarm: assert property (@(posedge clk) disable iff (sys_rst)
    modeWarn_q |-> !alarm_q[bmar_pkg::IDX_BATTERY])
    else $error("battery alarm raised in warning mode");

  a_warn_follows: assert property (@(posedge clk) disable iff (sys_rst)
    (stCont && batteryLow) |=> batteryWarning)
    else $error("battery warning missing in continuous check");

  a_hold_output: assert property (@(posedge clk) disable iff (sys_rst)
    stHold |=> servoFaultOutput)
    else $error("servo fault output low during power-up hold");

  a_nonreset_keeps: assert property (@(posedge clk) disable iff (sys_rst)
    (alarm_q[bmar_pkg::IDX_PRM_SUM] && alarmResetReq) |=> alarm_q[bmar_pkg::IDX_PRM_SUM])
    else $error("non-resettable alarm cleared by reset");

  a_reset_clears: assert property (@(posedge clk) disable iff (sys_rst)
    (alarm_q[bmar_pkg::IDX_MAIN] && alarmResetReq && !mainCircuitErr)
    |=> !alarm_q[bmar_pkg::IDX_MAIN])
    else $error("resettable alarm not cleared");

  a_error_code: assert property (@(posedge clk) disable iff (sys_rst)
    anyAlarm |=> errorCode_q == {4'h0, $past(activeCode)})
    else $error("error code object wrong");

  a_emcy_sent: assert property (@(posedge clk) disable iff (sys_rst)
    newSet |-> ##2 (emcyValid && emcyCode == {4'h0, $past(activeCode)}))
    else $error("emergency message not raised for new alarm");

  a_emcy_holds: assert property (@(posedge clk) disable iff (sys_rst)
    (emcyValid && !emcyReady && !emcyGiveUp) |=> emcyValid)
    else $error("emergency message withdrawn before acceptance");

  a_emcy_drop: assert property (@(posedge clk) disable iff (sys_rst)
    (emcyValid && emcyReady && !newAlarm_q) |=> !emcyValid)
    else $error("emergency message offered after acceptance");

  a_stop_group: assert property (@(posedge clk) disable iff (sys_rst)
    |(alarm_q & bmar_pkg::ALARM_STOP_GROUP_ONE) |=> stopGroupOne)
    else $error("stop group one output missing");

  a_format_set: assert property (@(posedge clk) disable iff (sys_rst)
    paramFormatErr |=> alarm_q[bmar_pkg::IDX_PRM_FMT])
    else $error("parameter format alarm not raised");

  a_main_set: assert property (@(posedge clk) disable iff (sys_rst)
    mainCircuitErr |=> alarm_q[bmar_pkg::IDX_MAIN])
    else $error("main circuit alarm not raised");

  a_dark_panel: assert property (@(posedge clk) disable iff (sys_rst)
    (anyAlarm && (panelChar != bmar_pkg::CHR_BLANK) && !panelLit)
    |-> ##2 alarm_q[bmar_pkg::IDX_SYS_24])
    else $error("dark panel not reported as system error");

  a_panel_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !anyAlarm |=> (panelChar == bmar_pkg::CHR_BLANK))
    else $error("panel not blank without alarm");

  a_warn_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    !stCont |=> !batteryWarning)
    else $error("battery warning outside continuous check");

  a_fault_on_alarm: assert property (@(posedge clk) disable iff (sys_rst)
    anyAlarm |=> servoFaultOutput)
    else $error("servo fault output low during alarm");

  a_read_ack: assert property (@(posedge clk) disable iff (sys_rst)
    objReadReq |=> objReadAck)
    else $error("object read not acknowledged");

  a_read_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
    (objReadReq && (objIndex != bmar_pkg::OBJ_ERROR_CODE)
      && (objIndex != bmar_pkg::OBJ_STATUS_WORD)) |=> (objReadErr && objReadData == 16'h0000))
    else $error("unmapped object read not refused");

  a_top_priority: assert property (@(posedge clk) disable iff (sys_rst)
    alarm_q[bmar_pkg::IDX_PRM_SUM]
    |=> errorCode_q == {4'h0, bmar_pkg::ALARM_CODES[bmar_pkg::IDX_PRM_SUM]})
    else $error("highest priority alarm code not reported");

endmodule
`default_nettype wire

// >>> testbench/bmar_host_model.sv
// Host controller model: accepts emergency messages from the alarm unit.
// Assumes one clock; slow mode holds off acceptance for a few cycles.
`timescale 1ns/1ps
`default_nettype none
module bmar_host_model (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        emcyValid,
  input  wire logic [15:0] emcyCode,
  input  wire logic        slow,
  output logic             emcyReady,
  output logic             taken,
  output logic      [15:0] takenCode
);
  logic [3:0] waitCnt;

  // Slow mode stays inside the sender's give-up time so messages still land
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      emcyReady <= 1'b0;
      taken     <= 1'b0;
      takenCode <= 16'h0000;
      waitCnt   <= 4'h0;
    end else begin
      taken   <= emcyValid && emcyReady;
      waitCnt <= (emcyValid && !emcyReady) ? waitCnt + 4'h1 : 4'h0;
      emcyReady <= emcyValid && !emcyReady && (!slow || waitCnt >= 4'h2);
      if (emcyValid && emcyReady) begin
        takenCode <= emcyCode;
      end
    end
  end
endmodule
`default_nettype wire

// >>> testbench/battery_monitor_alarm_reporting_bench.sv
// Self-checking bench for the battery monitor and alarm unit.
// Assumes shortened counts: hold 20, window 20, dwell 3, give-up 8 cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin compares++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %s", $time, m); end end
module battery_monitor_alarm_reporting_bench;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        batteryLow = 1'b0;
  logic [3:0]  digit = 4'h0;
  logic [4:0]  causeVec = 5'h00;
  logic        mainErr = 1'b0;
  logic        rstReq = 1'b0;
  logic        darkPanel = 1'b0;
  logic        slowHost = 1'b0;
  logic        objReadReq = 1'b0;
  logic [15:0] objIndex = 16'h0000;
  logic        objReadAck, objReadErr, emcyValid, emcyReady, servoFault;
  logic        batWarn, stopOne, taken, panelLit;
  logic [15:0] objReadData, emcyCode, takenCode;
  logic [4:0]  panelChar;
  logic [16:0] expQ[$];
  logic [16:0] expHead;
  logic [15:0] codes[5] = '{16'h0020, 16'h0021, 16'h0022, 16'h0024, 16'h0025};
  logic [4:0]  seq[6] = '{5'h10, 5'h11, 5'h00, 5'h03, 5'h00, 5'h1F};
  int          n_errors = 0;
  int          compares = 0;
  int          cycles = 0;

  // Panel feedback follows the display unless a dark panel is simulated
  assign panelLit = !darkPanel && (panelChar != bmar_pkg::CHR_BLANK);

  bmar_alarm_unit #(.HOLD_CYCLES(20), .MONITOR_CYCLES(20), .CHAR_DWELL(3),
    .EMCY_TIMEOUT(8)) i_dut (
    .clk(clk), .sys_rst(sys_rst), .batteryLow(batteryLow),
    .batteryAlarmSelectParam(digit), .paramChecksumErr(causeVec[0]),
    .paramFormatErr(causeVec[1]), .systemChecksumErr(causeVec[2]),
    .programErrA(causeVec[3]), .programErrB(causeVec[4]), .mainCircuitErr(mainErr),
    .panelLit(panelLit), .alarmResetReq(rstReq), .objReadReq(objReadReq),
    .objIndex(objIndex), .objReadAck(objReadAck), .objReadErr(objReadErr),
    .objReadData(objReadData), .emcyValid(emcyValid), .emcyCode(emcyCode),
    .emcyReady(emcyReady), .servoFaultOutput(servoFault), .batteryWarning(batWarn),
    .stopGroupOne(stopOne), .panelChar(panelChar));

  bmar_host_model i_host (
    .clk(clk), .sys_rst(sys_rst), .emcyValid(emcyValid), .emcyCode(emcyCode),
    .slow(slowHost), .emcyReady(emcyReady), .taken(taken), .takenCode(takenCode));

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      results();
    end
  end

  // Answers come back in request order, so the oldest note is the match
  always @(posedge clk) begin
    if (objReadAck === 1'b1) begin
      if (expQ.size() == 0) `CHK(1'b0, 1'b1, "unexpected acknowledge")
      else begin
        expHead = expQ.pop_front();
        `CHK({objReadErr, objReadData}, expHead, "object read")
      end
    end
  end

  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd(logic [15:0] idx, logic [15:0] d, logic err);
    expQ.push_back({err, d});
    objReadReq = 1'b1;
    objIndex = idx;
    step();
    objReadReq = 1'b0;
    step(2);
  endtask

  task automatic powerUp(logic [3:0] dig, logic low);
    sys_rst = 1'b1;
    digit = dig;
    batteryLow = low;
    step(8);
    sys_rst = 1'b0;
    step(5);
    `CHK(servoFault, 1'b1, "fault output in hold")
    step(40);
  endtask

  task automatic pulseReset();
    rstReq = 1'b1;
    step(2);
    rstReq = 1'b0;
    step(2);
  endtask

  task automatic waitEmcy(logic [15:0] c);
    for (int i = 0; i < 12 && taken !== 1'b1; i++) step();
    `CHK(takenCode, c, "emergency code")
  endtask

  task automatic results();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  initial begin
    void'($urandom(7));
    powerUp(4'h0, 1'b0);
    `CHK(servoFault, 1'b0, "fault output after hold")
    rd(bmar_pkg::OBJ_STATUS_WORD, 16'h0000, 1'b0);
    rd(bmar_pkg::OBJ_ERROR_CODE, 16'h0000, 1'b0);
    repeat (3) rd({4'h7, 12'($urandom)}, 16'h0000, 1'b1);
    $display("test idle done");
    slowHost = 1'b1;
    mainErr = 1'b1;
    waitEmcy(16'h0030);
    step(2);
    rd(bmar_pkg::OBJ_ERROR_CODE, 16'h0030, 1'b0);
    `CHK(stopOne, 1'b1, "stop group one")
    pulseReset();
    rd(bmar_pkg::OBJ_STATUS_WORD, 16'h0008, 1'b0);
    for (int i = 0; i < 30 && panelChar !== bmar_pkg::CHR_A; i++) step();
    foreach (seq[k]) begin
      `CHK(panelChar, seq[k], "panel character")
      step(3);
    end
    mainErr = 1'b0;
    step();
    pulseReset();
    rd(bmar_pkg::OBJ_STATUS_WORD, 16'h0000, 1'b0);
    slowHost = 1'b0;
    $display("test resettable done");
    for (int k = 0; k < 5; k++) begin
      powerUp(4'h0, 1'b0);
      causeVec = 5'(1 << k);
      step();
      causeVec = 5'h00;
      waitEmcy(codes[k]);
      pulseReset();
      rd(bmar_pkg::OBJ_ERROR_CODE, codes[k], 1'b0);
      `CHK(stopOne, 1'b1, "stop group one")
    end
    $display("test fixed alarms done");
    powerUp(4'h0, 1'b0);
    mainErr = 1'b1;
    step(2);
    mainErr = 1'b0;
    darkPanel = 1'b1;
    step(20);
    rd(bmar_pkg::OBJ_ERROR_CODE, 16'h0024, 1'b0);
    darkPanel = 1'b0;
    $display("test dark panel done");
    powerUp(4'h0, 1'b1);
    rd(bmar_pkg::OBJ_ERROR_CODE, 16'h0830, 1'b0);
    `CHK(servoFault, 1'b1, "fault output on battery alarm")
    `CHK(stopOne, 1'b0, "battery alarm stop group")
    pulseReset();
    rd(bmar_pkg::OBJ_STATUS_WORD, 16'h0008, 1'b0);
    powerUp(4'h2 + 4'($urandom % 14), 1'b0);
    batteryLow = 1'b1;
    step(10);
    rd(bmar_pkg::OBJ_STATUS_WORD, 16'h0000, 1'b0);
    `CHK(batWarn, 1'b0, "no warning in alarm mode")
    $display("test battery alarm done");
    powerUp(4'h1, 1'b1);
    `CHK(batWarn, 1'b1, "battery warning")
    `CHK(servoFault, 1'b0, "warning leaves fault output low")
    rd(bmar_pkg::OBJ_STATUS_WORD, 16'h0000, 1'b0);
    digit = 4'h0;
    batteryLow = 1'b0;
    step(3);
    `CHK(batWarn, 1'b0, "warning follows battery")
    batteryLow = 1'b1;
    step(3);
    `CHK(batWarn, 1'b1, "digit change waits for restart")
    $display("test battery warning done");
    `CHK(expQ.size(), 0, "reads left unanswered")
    results();
  end
endmodule
`undef CHK
`default_nettype wire
